// [verilog/rplm_pkg.sv]
`default_nettype none
package rplm_pkg;
  // Register offsets: shared port select, then the per-port page
  localparam logic [7:0] OFF_PORT_SEL = 8'h4C;
  localparam logic [7:0] OFF_LINES_HI = 8'h73;
  localparam logic [7:0] OFF_LINES_LO = 8'h74;
  localparam logic [7:0] OFF_LEN_HI = 8'h75;
  localparam logic [7:0] OFF_LEN_LO = 8'h76;
  localparam logic [7:0] OFF_FREQ_CTL = 8'h77;
  localparam logic [7:0] OFF_MSG0 = 8'h78;
  localparam logic [7:0] OFF_MSG1 = 8'h79;
  // Reset values
  localparam logic [7:0] RST_FREQ_CTL = 8'hC5;
  localparam logic [7:0] RST_MSG0 = 8'h00;
  localparam logic [7:0] RST_MSG1 = 8'h01;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  // Field positions in the frequency detect control register
  localparam int HYST_HI = 7;
  localparam int HYST_LO = 6;
  localparam int STAB_HI = 5;
  localparam int STAB_LO = 4;
  localparam int LOTHR_HI = 3;
  localparam int LOTHR_LO = 0;
  // Widths
  localparam int PORT_SEL_W = 2;
  localparam int STAB_CNT_W = 17;
  localparam logic [15:0] ONE_LINE = 16'h0001;
  localparam logic [STAB_CNT_W-1:0] CNT_ONE = 17'h00001;
  localparam logic [STAB_CNT_W-1:0] CNT_ZERO = 17'h00000;
  // Stability times and clock period in ns, then stability times in clock cycles
  localparam int CLK_PERIOD_NS = 25;
  localparam int STAB_T0_NS = 40000;
  localparam int STAB_T1_NS = 80000;
  localparam int STAB_T2_NS = 320000;
  localparam int STAB_T3_NS = 1280000;
  localparam int STAB_CYC_0 = STAB_T0_NS / CLK_PERIOD_NS;
  localparam int STAB_CYC_1 = STAB_T1_NS / CLK_PERIOD_NS;
  localparam int STAB_CYC_2 = STAB_T2_NS / CLK_PERIOD_NS;
  localparam int STAB_CYC_3 = STAB_T3_NS / CLK_PERIOD_NS;
endpackage : rplm_pkg
`default_nettype wire

// [verilog/rplm_freq_det.sv]
`timescale 1ns/1ps
`default_nettype none
module rplm_freq_det import rplm_pkg::*; #(
  parameter int unsigned CYC_0 = STAB_CYC_0,
  parameter int unsigned CYC_1 = STAB_CYC_1,
  parameter int unsigned CYC_2 = STAB_CYC_2,
  parameter int unsigned CYC_3 = STAB_CYC_3
) (
  // Clock and synchronised reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Measurement from the link clock counter
  input wire logic meas_valid,
  input wire logic [7:0] meas_mhz,
  // Settings
  input wire logic [1:0] freq_hysteresis,
  input wire logic [1:0] freq_stable_time_select,
  input wire logic [3:0] freq_low_threshold,
  // Status
  output logic no_link_clock_status,
  output logic freq_stable
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] cur_r, cur_nxt; // Accepted frequency
  logic have_r, have_nxt; // A measurement was ever accepted
  logic [STAB_CNT_W-1:0] cnt_r, cnt_nxt; // Cycles since last accept
  logic stab_r, stab_nxt;
  logic nolk_r, nolk_nxt;
  logic [7:0] diff; // Distance of new sample from current
  logic [STAB_CNT_W-1:0] limit; // Selected stability time

  // Stability time lookup
  always_comb begin
    case (freq_stable_time_select)
      2'h0: limit = STAB_CNT_W'(CYC_0);
      2'h1: limit = STAB_CNT_W'(CYC_1);
      2'h2: limit = STAB_CNT_W'(CYC_2);
      default: limit = STAB_CNT_W'(CYC_3);
    endcase
  end

  // Next state: accept outside hysteresis, count stability time
  always_comb begin
    diff = (meas_mhz > cur_r) ? (meas_mhz - cur_r) : (cur_r - meas_mhz);
    cur_nxt = cur_r;
    have_nxt = have_r;
    cnt_nxt = cnt_r;
    if (meas_valid && (!have_r || diff > {6'h00, freq_hysteresis})) begin
      cur_nxt = meas_mhz;
      have_nxt = 1'b1;
      cnt_nxt = CNT_ZERO; // Jump restarts the stability window
    end else if (have_r && cnt_r < limit) begin
      cnt_nxt = cnt_r + CNT_ONE; // Saturates at the limit
    end
    // Select change takes effect at once, no restart
    stab_nxt = have_nxt && (cnt_nxt >= limit);
    // No clock at all also counts as below threshold
    nolk_nxt = !have_nxt || (cur_nxt < {4'h0, freq_low_threshold});
  end

  // Registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cur_r <= RST_BYTE;
      have_r <= 1'b0;
      cnt_r <= CNT_ZERO;
      stab_r <= 1'b0;
      nolk_r <= 1'b1;
    end else begin
      cur_r <= cur_nxt;
      have_r <= have_nxt;
      cnt_r <= cnt_nxt;
      stab_r <= stab_nxt;
      nolk_r <= nolk_nxt;
    end
  end

  assign no_link_clock_status = nolk_r;
  assign freq_stable = stab_r;

endmodule : rplm_freq_det
`default_nettype wire

// [verilog/rplm_top.sv]
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Line count low byte readable at 0x74
// - Line count high byte at 0x73, resets zero
// - Line count frozen until read when enabled
// - High byte read captures the low byte
// - Line length readable at 0x75/0x76, reset zero
// - Varying lengths report the frame's last line
// - Line length frozen until read when enabled
// - Length high read latches the low byte
// - Accept first frequency, later ones only beyond hysteresis setting
// - Stable after selected time within hysteresis
// - No-clock status when below low threshold
// - Two message registers, resets 0x00 and 0x01
// - Port select 0x4C routes per-port accesses
module rplm_top import rplm_pkg::*; #(
  parameter int NUM_PORTS = 4,
  parameter int unsigned STAB_CYCLES_0 = STAB_CYC_0,
  parameter int unsigned STAB_CYCLES_1 = STAB_CYC_1,
  parameter int unsigned STAB_CYCLES_2 = STAB_CYC_2,
  parameter int unsigned STAB_CYCLES_3 = STAB_CYC_3
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Register access from the serial target core
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Video timing per port
  input wire logic [NUM_PORTS-1:0] line_done,
  input wire logic [NUM_PORTS*16-1:0] line_len_in,
  input wire logic [NUM_PORTS-1:0] frame_done,
  // Change interrupt enables per port
  input wire logic [NUM_PORTS-1:0] line_total_change_irq_enable,
  input wire logic [NUM_PORTS-1:0] line_length_change_irq_enable,
  // Link clock measurement per port
  input wire logic [NUM_PORTS-1:0] freq_meas_valid,
  input wire logic [NUM_PORTS*8-1:0] freq_meas_mhz,
  // Status per port
  output logic [NUM_PORTS-1:0] no_link_clock_status,
  output logic [NUM_PORTS-1:0] freq_stable
);

  // Address match
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops; assertion stays asynchronous
  logic rst_meta_r;
  logic rst_n; // Synchronised reset for the whole block

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port select and read return
  logic [PORT_SEL_W-1:0] psel_r, psel_nxt; // Selected receive port
  logic [7:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [7:0] port_rdata [NUM_PORTS]; // Per-port read mux output

  // Next state for the shared registers
  always_comb begin
    psel_nxt = psel_r;
    if (reg_wr && hit(reg_addr, OFF_PORT_SEL)) begin
      psel_nxt = reg_wdata[PORT_SEL_W-1:0];
    end
    rvalid_nxt = reg_rd;
    rdata_nxt = rdata_r; // Holds last answer between reads
    if (reg_rd) begin
      if (hit(reg_addr, OFF_PORT_SEL)) begin
        rdata_nxt = {{(8-PORT_SEL_W){1'b0}}, psel_r};
      end else begin
        rdata_nxt = port_rdata[psel_r];
      end
    end
  end

  // Shared registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      psel_r <= '0;
      rdata_r <= RST_BYTE;
      rvalid_r <= 1'b0;
    end else begin
      psel_r <= psel_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;

  ////////////////////////////////////////////////////////////////////////////
  // One copy of the monitor registers per receive port
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    logic sel; // This port is the selected one
    logic rd_chi, rd_clo, rd_lhi, rd_llo; // Read strobes on this copy
    logic [15:0] len_in; // Length of the line just ended
    logic [15:0] run_r, run_nxt; // Lines seen so far this frame
    logic [15:0] last_r, last_nxt; // Length of latest line this frame
    logic [15:0] cnt_r, cnt_nxt; // Reported line count
    logic [15:0] len_r, len_nxt; // Reported line length
    logic cfrz_r, cfrz_nxt, lfrz_r, lfrz_nxt; // Freeze flags
    logic cpend_r, cpend_nxt, lpend_r, lpend_nxt; // High byte read, low pending
    logic [7:0] csh_r, csh_nxt, lsh_r, lsh_nxt; // Captured low bytes
    logic [7:0] ctl_r, ctl_nxt, msg0_r, msg0_nxt, msg1_r, msg1_nxt;

    assign sel = (psel_r == PORT_SEL_W'(p));
    assign rd_chi = reg_rd && sel && hit(reg_addr, OFF_LINES_HI);
    assign rd_clo = reg_rd && sel && hit(reg_addr, OFF_LINES_LO);
    assign rd_lhi = reg_rd && sel && hit(reg_addr, OFF_LEN_HI);
    assign rd_llo = reg_rd && sel && hit(reg_addr, OFF_LEN_LO);
    assign len_in = line_len_in[p*16 +: 16];

    // Next state of this port's registers
    always_comb begin
      run_nxt = run_r;
      last_nxt = last_r;
      if (line_done[p]) begin
        run_nxt = run_r + ONE_LINE;
        last_nxt = len_in; // Later lines overwrite earlier ones
      end
      if (frame_done[p]) begin
        run_nxt = RST_WORD; // New frame counts from zero
      end
      cnt_nxt = cnt_r;
      len_nxt = len_r;
      csh_nxt = csh_r;
      lsh_nxt = lsh_r;
      cpend_nxt = cpend_r;
      lpend_nxt = lpend_r;
      cfrz_nxt = cfrz_r;
      lfrz_nxt = lfrz_r;
      // High byte read captures the low byte
      if (rd_chi) begin
        csh_nxt = cnt_r[7:0];
        cpend_nxt = 1'b1;
      end
      if (rd_lhi) begin
        lsh_nxt = len_r[7:0];
        lpend_nxt = 1'b1;
      end
      // Low byte after high completes the read and lifts the freeze
      if (rd_clo && cpend_r) begin
        cpend_nxt = 1'b0;
        cfrz_nxt = 1'b0;
      end
      if (rd_llo && lpend_r) begin
        lpend_nxt = 1'b0;
        lfrz_nxt = 1'b0;
      end
      // Frame end reports unless frozen; a new freeze wins over release
      if (frame_done[p] && !cfrz_r) begin
        cnt_nxt = line_done[p] ? run_r + ONE_LINE : run_r;
        cfrz_nxt = line_total_change_irq_enable[p];
      end
      if (frame_done[p] && !lfrz_r) begin
        len_nxt = line_done[p] ? len_in : last_r;
        lfrz_nxt = line_length_change_irq_enable[p];
      end
      // Freezing stops once the enable drops
      if (!line_total_change_irq_enable[p]) begin
        cfrz_nxt = 1'b0;
      end
      if (!line_length_change_irq_enable[p]) begin
        lfrz_nxt = 1'b0;
      end
      // Writable settings and message registers
      ctl_nxt = ctl_r;
      msg0_nxt = msg0_r;
      msg1_nxt = msg1_r;
      if (reg_wr && sel) begin
        if (hit(reg_addr, OFF_FREQ_CTL)) begin
          ctl_nxt = reg_wdata;
        end
        if (hit(reg_addr, OFF_MSG0)) begin
          msg0_nxt = reg_wdata;
        end
        if (hit(reg_addr, OFF_MSG1)) begin
          msg1_nxt = reg_wdata;
        end
      end
    end

    // Registers of this port
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        run_r <= RST_WORD;
        last_r <= RST_WORD;
        cnt_r <= RST_WORD;
        len_r <= RST_WORD;
        cfrz_r <= 1'b0;
        lfrz_r <= 1'b0;
        cpend_r <= 1'b0;
        lpend_r <= 1'b0;
        csh_r <= RST_BYTE;
        lsh_r <= RST_BYTE;
        ctl_r <= RST_FREQ_CTL;
        msg0_r <= RST_MSG0;
        msg1_r <= RST_MSG1;
      end else begin
        run_r <= run_nxt;
        last_r <= last_nxt;
        cnt_r <= cnt_nxt;
        len_r <= len_nxt;
        cfrz_r <= cfrz_nxt;
        lfrz_r <= lfrz_nxt;
        cpend_r <= cpend_nxt;
        lpend_r <= lpend_nxt;
        csh_r <= csh_nxt;
        lsh_r <= lsh_nxt;
        ctl_r <= ctl_nxt;
        msg0_r <= msg0_nxt;
        msg1_r <= msg1_nxt;
      end
    end

    // Read mux; low bytes come from the capture while a pair is open
    always_comb begin
      case (reg_addr)
        OFF_LINES_HI: port_rdata[p] = cnt_r[15:8];
        OFF_LINES_LO: port_rdata[p] = cpend_r ? csh_r : cnt_r[7:0];
        OFF_LEN_HI: port_rdata[p] = len_r[15:8];
        OFF_LEN_LO: port_rdata[p] = lpend_r ? lsh_r : len_r[7:0];
        OFF_FREQ_CTL: port_rdata[p] = ctl_r;
        OFF_MSG0: port_rdata[p] = msg0_r;
        OFF_MSG1: port_rdata[p] = msg1_r;
        default: port_rdata[p] = RST_BYTE; // Unmapped reads as zero
      endcase
    end

    // Link clock frequency detector
    rplm_freq_det #(
      .CYC_0(STAB_CYCLES_0),
      .CYC_1(STAB_CYCLES_1),
      .CYC_2(STAB_CYCLES_2),
      .CYC_3(STAB_CYCLES_3)
    ) u_freq (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .meas_valid(freq_meas_valid[p]),
      .meas_mhz(freq_meas_mhz[p*8 +: 8]),
      .freq_hysteresis(ctl_r[HYST_HI:HYST_LO]),
      .freq_stable_time_select(ctl_r[STAB_HI:STAB_LO]),
      .freq_low_threshold(ctl_r[LOTHR_HI:LOTHR_LO]),
      .no_link_clock_status(no_link_clock_status[p]),
      .freq_stable(freq_stable[p])
    );
  end

endmodule : rplm_top
`default_nettype wire

// [verif/rplm_chk.sv]
`timescale 1ns/1ps
`default_nettype none
// Watches register answers and link clock status at the top ports
module rplm_chk import rplm_pkg::*; #(
  parameter int NUM_PORTS = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Register access
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // Link clock measurement and status
  input wire logic [NUM_PORTS-1:0] freq_meas_valid,
  input wire logic [NUM_PORTS*8-1:0] freq_meas_mhz,
  input wire logic [NUM_PORTS-1:0] no_link_clock_status,
  input wire logic [NUM_PORTS-1:0] freq_stable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // Every read answers exactly one cycle later
  AST_RD_ANSWER: assert property (reg_rd |=> reg_rvalid)
    else $error("read got no answer");
  AST_NO_SPURIOUS: assert property (!reg_rd |=> !reg_rvalid)
    else $error("answer without a read");
  // Read data only moves together with an answer
  AST_RDATA_HOLD: assert property (!reg_rvalid |-> $stable(reg_rdata))
    else $error("read data moved without answer");
  AST_UNMAPPED: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == RST_BYTE)
    else $error("hole read not zero");
  AST_SEL_LAYOUT: assert property (reg_rd && reg_addr == OFF_PORT_SEL |=> reg_rdata[7:2] == 6'h00)
    else $error("page register upper bits set");
  // Status only rises after a sample or a settings write
  // A threshold write reaches the status two edges after it is taken
  AST_NOCLK_RISE: assert property ($rose(no_link_clock_status[0]) |->
    $past(freq_meas_valid[0]) || $past(reg_wr, 2))
    else $error("no-clock status rose without sample");
  // A fast sample is above every 4-bit threshold
  AST_FAST_CLK: assert property (freq_meas_valid[0] && freq_meas_mhz[7:0] >= 8'h20 |=> !no_link_clock_status[0])
    else $error("fast clock reported missing");
  // A longer stability time selected by a write also drops it, two edges on
  AST_STABLE_DROP: assert property ($fell(freq_stable[0]) |->
    $past(freq_meas_valid[0]) || $past(reg_wr, 2))
    else $error("stable dropped without sample");
  // Shortest stability time is four cycles
  AST_STABLE_WAIT: assert property ($fell(freq_stable[0]) |-> !freq_stable[0] [*3])
    else $error("stable returned too soon");
endmodule : rplm_chk
bind rplm_top rplm_chk #(.NUM_PORTS(NUM_PORTS)) u_chk (.clk_sys(clk_sys), .arst_n(arst_n),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid),
  .freq_meas_valid(freq_meas_valid), .freq_meas_mhz(freq_meas_mhz),
  .no_link_clock_status(no_link_clock_status), .freq_stable(freq_stable));
`default_nettype wire

// [verif/rplm_host.sv]
`timescale 1ns/1ps
`default_nettype none
// Register host: one strobe per access, changed on the falling edge
module rplm_host import rplm_pkg::*; (
  // Clock
  input wire logic clk_sys,
  // Register requests
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // Strobe spans one rising edge; idle bus shows inverted values
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : acc
  // Page chosen before any per-port access
  task automatic sel(input logic [1:0] p);
    acc(1'b1, OFF_PORT_SEL, {6'h00, p});
  endtask : sel
endmodule : rplm_host
`default_nettype wire

// [verif/tb_rplm_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_rplm_top import rplm_pkg::*; ;
  // Short stability counts keep the run brief
  localparam int LIM [4] = '{4, 8, 16, 32};
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, reg_rvalid;
  logic [3:0] ln = 4'h0, fr = 4'h0, ie_cnt = 4'h0, ie_len = 4'h0, mv = 4'h0;
  logic [63:0] len_in = 64'h0;
  logic [31:0] mhz = 32'h0;
  logic [3:0] no_clk, stab;
  logic [7:0] q [$];
  int n_mismatch = 0;
  int compares = 0;
  always #12.5 clk_sys = ~clk_sys;
  rplm_host host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata));
  rplm_top #(.STAB_CYCLES_0(LIM[0]), .STAB_CYCLES_1(LIM[1]), .STAB_CYCLES_2(LIM[2]),
    .STAB_CYCLES_3(LIM[3])) dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .line_done(ln), .line_len_in(len_in),
    .frame_done(fr), .line_total_change_irq_enable(ie_cnt),
    .line_length_change_irq_enable(ie_len), .freq_meas_valid(mv), .freq_meas_mhz(mhz),
    .no_link_clock_status(no_clk), .freq_stable(stab));
  ////////////////////////////////////////
  task automatic results();
    if (n_mismatch == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Answers are matched in order against the noted reads
  always @(negedge clk_sys) begin
    if (reg_rvalid === 1'b1) begin
      check(reg_rdata, q.pop_front());
    end
  end
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    q.push_back(e);
    host.acc(1'b0, a, 8'h00);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.acc(1'b1, a, d);
  endtask : wr
  task automatic pair(input logic [7:0] a, input logic [15:0] v);
    rd(a, v[15:8]);
    rd(a + 8'h01, v[7:0]);
  endtask : pair
  // Last line coincides with the frame end, the awkward case
  task automatic frame(input int p, input int n, output logic [15:0] l);
    for (int i = 0; i < n; i++) begin
      l = 16'($urandom);
      @(negedge clk_sys);
      ln[p] = 1'b1;
      fr[p] = (i == n - 1);
      len_in[p*16+:16] = l;
      @(negedge clk_sys);
      ln[p] = 1'b0;
      fr[p] = 1'b0;
      len_in[p*16+:16] = ~l;
    end
  endtask : frame
  task automatic meas(input logic [7:0] m);
    @(negedge clk_sys);
    mv[0] = 1'b1;
    mhz[7:0] = m;
    @(negedge clk_sys);
    mv[0] = 1'b0;
    mhz[7:0] = ~m;
    @(negedge clk_sys);
  endtask : meas
  task automatic wait_stable(output int c);
    c = 0;
    while (stab[0] !== 1'b1 && c < 100) begin
      @(negedge clk_sys);
      c++;
    end
  endtask : wait_stable
  ////////////////////////////////////////
  initial begin
    logic [15:0] la, lb, lc;
    logic [7:0] m;
    int c;
    void'($urandom(32'hF097));
    repeat (16) @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    for (int i = 0; i < 9; i++) begin
      rd({8'h73 + 8'(i)}, 8'h00 + (i == 4 ? RST_FREQ_CTL : i == 6 ? RST_MSG1 : RST_BYTE));
    end
    m = 8'($urandom);
    host.sel(2'h1);
    wr(OFF_MSG0, m);
    wr(OFF_LEN_HI, 8'hFF);
    rd(OFF_MSG0, m);
    rd(OFF_LEN_HI, RST_BYTE);
    rd(OFF_PORT_SEL, 8'h01);
    rd(8'h00, RST_BYTE);
    host.sel(2'h0);
    rd(OFF_MSG0, RST_MSG0);
    wr(OFF_MSG1, ~m);
    rd(OFF_MSG1, ~m);
    host.sel(2'h2);
    frame(2, 258, la);
    frame(3, 4, lb);
    pair(OFF_LINES_HI, 16'h0102);
    pair(OFF_LEN_HI, la);
    rd(OFF_LINES_HI, 8'h01);
    rd(OFF_LEN_HI, la[15:8]);
    frame(2, 3, lb);
    rd(OFF_LINES_LO, 8'h02);
    rd(OFF_LEN_LO, la[7:0]);
    pair(OFF_LINES_HI, 16'h0003);
    pair(OFF_LEN_HI, lb);
    ie_cnt[3] = 1'b1;
    ie_len[3] = 1'b1;
    host.sel(2'h3);
    frame(3, 5, la);
    frame(3, 7, lb);
    pair(OFF_LINES_HI, 16'h0005);
    pair(OFF_LEN_HI, la);
    frame(3, 9, lc);
    pair(OFF_LINES_HI, 16'h0009);
    pair(OFF_LEN_HI, lc);
    host.sel(2'h0);
    wr(OFF_FREQ_CTL, 8'h05);
    meas(8'h03);
    check({7'h00, no_clk[0]}, 8'h01);
    meas(8'h14);
    check({7'h00, no_clk[0]}, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wr(OFF_FREQ_CTL, {2'b00, 2'(s), 4'h5});
      meas(8'h20 + 8'(s * 4));
      wait_stable(c);
      check({7'h00, c >= LIM[s] - 2 && c <= LIM[s] + 2}, 8'h01);
    end
    wr(OFF_FREQ_CTL, RST_FREQ_CTL);
    meas(8'h2F);
    check({7'h00, stab[0]}, 8'h01);
    meas(8'h30);
    check({7'h00, stab[0]}, 8'h00);
    wr(OFF_FREQ_CTL, 8'hCF);
    meas(8'h0A);
    check({7'h00, no_clk[0]}, 8'h01);
    meas(8'h0F);
    check({7'h00, no_clk[0]}, 8'h00);
    repeat (4) @(negedge clk_sys);
    check(8'(q.size()), 8'h00);
    results();
  end
  // Hang guard, far beyond the expected run
  initial begin
    #500000;
    n_mismatch++;
    results();
  end
endmodule : tb_rplm_top
`default_nettype wire
